// *** rtl/external_interrupt_line_line_source_select.sv ***
// Source selector for external interrupt lines 8 to 15 with an Avalon-MM register slave.
`timescale 1ns/10ps
`include "external_interrupt_line_src_consts.svh"
module external_interrupt_line_line_source_select
	import external_interrupt_line_src_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [7:0] portAPins,
	input wire logic [7:0] portBPins,
	input wire logic [2:0] portCPins,
	output logic [7:0] lineLevel
);

	// Merges the two low byte lanes of a write into a 16-bit field store.
	function automatic logic [15:0] mergeLanes(logic [15:0] old, logic [31:0] wdata, logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			res[15:8] = wdata[15:8];
		end
		return res;
	endfunction : mergeLanes

	logic [15:0] selLoQ;
	logic [15:0] selHiQ;
	logic [15:0] selLoD;
	logic [15:0] selHiD;
	logic ackQ;
	logic [31:0] readDataQ;
	logic [31:0] readDataD;
	logic [`PIN_COUNT-1:0] pinRaw;
	logic [`PIN_COUNT-1:0] sync1Q;
	logic [`PIN_COUNT-1:0] sync2Q;
	logic [`PIN_COUNT-1:0] sync3Q;
	logic [`PIN_COUNT-1:0] pinStableQ;
	logic [`PIN_COUNT-1:0] pinStableD;
	logic [7:0] lineLevelQ;
	logic request;
	logic hitLo;
	logic hitHi;
	logic writeLo;
	logic writeHi;
	logic captureRead;

	line_sel_if selBus ();

	// Bus decode: one wait cycle, then the access completes.
	assign request = read | write;
	assign waitrequest = request & ~ackQ;
	assign captureRead = read & ~ackQ;
	assign hitLo = (address == `OFF_SEL_8_TO_11);
	assign hitHi = (address == `OFF_SEL_12_TO_15);
	assign writeLo = write & ackQ & hitLo;
	assign writeHi = write & ackQ & hitHi;

	// Only the low 16 bits hold fields; the upper half is never stored.
	assign selLoD = writeLo ? mergeLanes(selLoQ, writedata, byteenable) : selLoQ;
	assign selHiD = writeHi ? mergeLanes(selHiQ, writedata, byteenable) : selHiQ;

	// Read mux; unmapped offsets and reserved bits read as zero.
	assign readDataD = hitLo ? {`UPPER_ZERO, selLoQ} :
		hitHi ? {`UPPER_ZERO, selHiQ} : 32'h0000_0000;

	// Acknowledge flag: one cycle of wait, one cycle of completion.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ackQ <= 1'b0;
		end else begin
			ackQ <= request & ~ackQ;
		end
	end

	// Read data is latched in the wait cycle and stands in the completion cycle.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			readDataQ <= 32'h0000_0000;
		end else if (captureRead) begin
			readDataQ <= readDataD;
		end
	end

	// Source-select registers.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			selLoQ <= `SEL_RESET;
			selHiQ <= `SEL_RESET;
		end else begin
			selLoQ <= selLoD;
			selHiQ <= selHiD;
		end
	end

	assign readdata = readDataQ;

	// Pin synchroniser: three stages, first stage feeds only the second.
	assign pinRaw = {portCPins, portBPins, portAPins};

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1Q <= '0;
			sync2Q <= '0;
			sync3Q <= '0;
		end else begin
			sync1Q <= pinRaw;
			sync2Q <= sync1Q;
			sync3Q <= sync2Q;
		end
	end

	// A pin change counts once the second and third stages agree.
	assign pinStableD = (pinStableQ & (sync2Q ^ sync3Q)) | (sync3Q & ~(sync2Q ^ sync3Q));

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pinStableQ <= '0;
		end else begin
			pinStableQ <= pinStableD;
		end
	end

	// Feed the multiplexer; line 8 code in bits 3:0 of the first register.
	assign selBus.codes = line_codes_t'({selHiQ, selLoQ});
	assign selBus.pinA = pinStableQ[7:0];
	assign selBus.pinB = pinStableQ[15:8];
	assign selBus.pinC = pinStableQ[18:16];

	line_source_mux uMux (
		.sel(selBus.mux)
	);

	// Line levels leave the block from flip-flops.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lineLevelQ <= '0;
		end else begin
			lineLevelQ <= selBus.level;
		end
	end

	assign lineLevel = lineLevelQ;

	// Checks on the register slave and the routing.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// After reset both registers are clear.
	chk_reset_clear: assert property ($rose(rst_b) |-> (selLoQ == `SEL_RESET) && (selHiQ == `SEL_RESET))
		else $error("Select registers not clear after reset.");

	// Every request completes after exactly one wait cycle.
	chk_wait_bound: assert property ($rose(request) |-> waitrequest ##1 !waitrequest)
		else $error("Bus access did not complete after one wait cycle.");

	// A full-lane write to the first register is stored in the low half.
	chk_write_store: assert property (write && !waitrequest && hitLo && byteenable == 4'hf
		|=> selLoQ == $past(writedata[15:0]))
		else $error("Write to first select register was not stored.");

	// A completed read of the second register returns it with a zero upper half.
	chk_read_back: assert property (read && !waitrequest && hitHi |-> readdata == {`UPPER_ZERO, selHiQ})
		else $error("Read of second select register returned a wrong value.");

	// Upper half never reads back nonzero, whatever was written.
	chk_upper_zero: assert property (read && !waitrequest |-> readdata[31:16] == `UPPER_ZERO)
		else $error("Upper register half read back nonzero.");

	// Line 8 on code 0000 follows port A pin 8 one cycle later.
	chk_route_a_line: assert property (selLoQ[3:0] == `SRC_CODE_PORT_A
		|=> lineLevel[0] == $past(pinStableQ[0]))
		else $error("Line 8 did not follow port A pin 8.");

	// Line 11 on code 0001 follows port B pin 11.
	chk_route_b_line: assert property (selLoQ[15:12] == `SRC_CODE_PORT_B
		|=> lineLevel[3] == $past(pinStableQ[11]))
		else $error("Line 11 did not follow port B pin 11.");

	// Line 13 on code 0010 follows port C pin 13.
	chk_route_c_line: assert property (selHiQ[7:4] == `SRC_CODE_PORT_C
		|=> lineLevel[5] == $past(pinStableQ[16]))
		else $error("Line 13 did not follow port C pin 13.");

	// Line 12 has no port C, so code 0010 holds it low.
	chk_no_c_low: assert property (selHiQ[3:0] == `SRC_CODE_PORT_C |=> !lineLevel[4])
		else $error("Line 12 not low on a reserved code.");

	// A reserved code on line 15 holds it low.
	chk_reserved_low: assert property (selHiQ[15:12] > `SRC_CODE_PORT_C |=> !lineLevel[7])
		else $error("Line 15 not low on a reserved code.");

	// A pin change reaches the stable level only after two agreeing stages.
	chk_sync_agree: assert property ((sync2Q[0] != sync3Q[0]) |=> pinStableQ[0] == $past(pinStableQ[0]))
		else $error("Pin level changed before synchroniser stages agreed.");

	// A full-lane write to the second register is stored in its low half.
	chk_write_hi: assert property (write && !waitrequest && hitHi && byteenable == 4'hf
		|=> selHiQ == $past(writedata[15:0]))
		else $error("Write to second select register was not stored.");

	// A write with only the lowest lane enabled leaves the upper field byte alone.
	chk_lane_keep: assert property (write && !waitrequest && hitLo && byteenable[1:0] == 2'b01
		|=> selLoQ[15:8] == $past(selLoQ[15:8]))
		else $error("Disabled byte lane of first select register changed.");

	// A completed read of an unmapped offset returns zero.
	chk_unmapped_zero: assert property (read && !waitrequest && !hitLo && !hitHi |-> readdata == 32'h0000_0000)
		else $error("Unmapped offset read back nonzero.");

endmodule : external_interrupt_line_line_source_select

// *** rtl/external_interrupt_line_src_consts.svh ***
// Named constants for the external interrupt line source selector.
`ifndef EXTERNAL_INTERRUPT_LINE_SRC_CONSTS_SVH
`define EXTERNAL_INTERRUPT_LINE_SRC_CONSTS_SVH

// Byte offsets of the two source-select registers on the register bus.
`define OFF_SEL_8_TO_11 5'h10
`define OFF_SEL_12_TO_15 5'h14

// Reset value of the implemented low half of each register.
`define SEL_RESET 16'h0000

// Select codes that route a pin onto a line.
`define SRC_CODE_PORT_A 4'h0
`define SRC_CODE_PORT_B 4'h1
`define SRC_CODE_PORT_C 4'h2

// Geometry of the lines served by this block.
`define LINE_COUNT 8
`define FIELD_WIDTH 4
`define FIRST_PORT_C_LINE 5
`define PORT_C_PINS 3
`define PIN_COUNT 19

// Read value of the reserved upper half of each register.
`define UPPER_ZERO 16'h0000

`endif

// *** rtl/external_interrupt_line_src_pkg.sv ***
// Types shared by the external interrupt line source selector.
package external_interrupt_line_src_pkg;

	// One 4-bit source code per line.
	typedef logic [3:0] src_code_t;

	// Codes of lines 8 to 15; element 0 is line 8.
	typedef src_code_t [7:0] line_codes_t;

endpackage : external_interrupt_line_src_pkg

// *** rtl/line_sel_if.sv ***
// Carrier between the register side and the line multiplexer.
`timescale 1ns/10ps
interface line_sel_if;
	import external_interrupt_line_src_pkg::*;

	// Programmed codes, filtered pin levels and the resulting line levels.
	line_codes_t codes;
	logic [7:0] pinA;
	logic [7:0] pinB;
	logic [2:0] pinC;
	logic [7:0] level;

	modport regs (output codes, output pinA, output pinB, output pinC, input level);
	modport mux (input codes, input pinA, input pinB, input pinC, output level);
endinterface : line_sel_if

// *** rtl/line_source_mux.sv ***
// Per-line pin selection for external interrupt lines 8 to 15.
`timescale 1ns/10ps
`include "external_interrupt_line_src_consts.svh"
module line_source_mux
	import external_interrupt_line_src_pkg::*;
(
	line_sel_if.mux sel
);

	// Decodes one code into a level; unlisted codes drive a constant low.
	function automatic logic pickLevel(src_code_t code, logic a, logic b, logic c, logic hasC);
		logic lvl;
		lvl = 1'b0;
		case (code)
			`SRC_CODE_PORT_A: lvl = a;
			`SRC_CODE_PORT_B: lvl = b;
			`SRC_CODE_PORT_C: lvl = hasC & c;
			default: lvl = 1'b0;
		endcase
		return lvl;
	endfunction : pickLevel

	// Lines 8 to 12 know ports A and B only; lines 13 to 15 add port C.
	for (genvar i = 0; i < `LINE_COUNT; i++) begin : gLine
		if (i >= `FIRST_PORT_C_LINE) begin : gWithC
			assign sel.level[i] = pickLevel(sel.codes[i], sel.pinA[i], sel.pinB[i],
				sel.pinC[i - `FIRST_PORT_C_LINE], 1'b1);
		end else begin : gNoC
			assign sel.level[i] = pickLevel(sel.codes[i], sel.pinA[i], sel.pinB[i], 1'b0, 1'b0);
		end
	end

endmodule : line_source_mux

// *** tb/edge_detect_model.sv ***
// Behavioural edge detector that stands where the interrupt controller takes the line levels.
`timescale 1ns/10ps
module edge_detect_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [7:0] lineLevel,
	output logic [7:0] risingSeen
);
	logic [7:0] lastQ;

	// Remembers each line level and latches every rising edge seen on it.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lastQ <= 8'h00;
			risingSeen <= 8'h00;
		end else begin
			lastQ <= lineLevel;
			risingSeen <= risingSeen | (lineLevel & ~lastQ);
		end
	end
endmodule : edge_detect_model

// *** tb/tb.sv ***
// Self-checking bench for the external interrupt line source selector.
`timescale 1ns/10ps
module tb;
	import external_interrupt_line_src_pkg::*;
	logic ref_clk, rst_b, read, write, waitrequest;
	logic [4:0] address;
	logic [31:0] writedata, readdata, q, v, m;
	logic [3:0] byteenable;
	logic [7:0] portAPins, portBPins, lineLevel, risingSeen;
	logic [2:0] portCPins;
	int errCount = 0;
	int nTests = 0;
	int cycles = 0;
	int regs[2];

	// Free-running 100 MHz clock.
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	external_interrupt_line_line_source_select DUT (.ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .portAPins(portAPins), .portBPins(portBPins),
		.portCPins(portCPins), .lineLevel(lineLevel));
	edge_detect_model farSide (.ref_clk(ref_clk), .rst_b(rst_b), .lineLevel(lineLevel),
		.risingSeen(risingSeen));

	// Cuts a hung run short and counts it as a mismatch.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errCount++;
			printVerdict();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One Avalon transfer, held until waitrequest is sampled low, then one idle cycle.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'h0);
		r = readdata;
		read <= 1'h0;
		write <= 1'h0;
		@(posedge ref_clk);
	endtask : bus

	// Compares every line level with the level that the model selects.
	task automatic checkLines();
		logic [7:0] e;
		int c;
		for (int n = 0; n < 8; n++) begin
			c = (regs[n / 4] >> (4 * (n % 4))) & 15;
			e[n] = (c == 0) ? portAPins[n] : (c == 1) ? portBPins[n] :
				(c == 2 && n > 4) ? portCPins[(n + 1) % 3] : 1'h0;
		end
		check({24'h0, lineLevel}, {24'h0, e});
	endtask : checkLines

	task automatic printVerdict();
		$display("compares %0d, mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : printVerdict

	// Main sequence: reset values, every code on every line, random fields with lanes.
	initial begin
		rst_b = 1'h0;
		read = 1'h0;
		write = 1'h0;
		address = 5'h0;
		writedata = 32'h0;
		byteenable = 4'hf;
		portAPins = 8'h0;
		portBPins = 8'h0;
		portCPins = 3'h0;
		regs[0] = 0;
		regs[1] = 0;
		void'($urandom(32'h4be5));
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'h1;
		@(posedge ref_clk);
		bus(1'h0, 5'h10, 32'h0, q); check(q, 32'h0);
		bus(1'h0, 5'h14, 32'h0, q); check(q, 32'h0);
		bus(1'h1, 5'h18, 32'h0000ffff, q);
		bus(1'h0, 5'h18, 32'h0, q); check(q, 32'h0);
		portAPins <= $urandom;
		portBPins <= $urandom;
		repeat (7) @(posedge ref_clk);
		checkLines();
		check({24'h0, risingSeen}, {24'h0, portAPins});
		$display("test reset values done");
		for (int k = 0; k < 16; k++) begin
			v = {16'h0, {4{k[3:0]}}};
			bus(1'h1, 5'h10, v, q);
			bus(1'h1, 5'h14, v, q);
			regs[0] = v;
			regs[1] = v;
			portAPins <= $urandom;
			portBPins <= $urandom;
			portCPins <= $urandom;
			repeat (7) @(posedge ref_clk);
			checkLines();
		end
		$display("test all codes done");
		for (int k = 0; k < 12; k++) begin
			v = $urandom;
			for (int n = 0; n < 4; n++) begin
				v[4 * n +: 4] = v[4 * n +: 4] % ((k[0] && n > 0) ? 3 : 2);
			end
			byteenable <= $urandom;
			m = 32'h0;
			bus(1'h1, k[0] ? 5'h14 : 5'h10, {16'h0, v[15:0]}, q);
			if (byteenable[0]) m = m | 32'h00ff;
			if (byteenable[1]) m = m | 32'hff00;
			regs[k[0]] = (regs[k[0]] & ~m) | (v & m);
			bus(1'h0, k[0] ? 5'h14 : 5'h10, 32'h0, q); check(q, regs[k[0]]);
			checkLines();
		end
		$display("test random fields done");
		printVerdict();
	end
endmodule : tb
